/* File: core/ftct_defs.vh */
`ifndef FTCT_DEFS_VH
`define FTCT_DEFS_VH
// expected status vector layout: {fcs_valid, e, a, c}
`define FTCT_EXP_W 4
`define FTCT_EXP_FCSV 3
`define FTCT_EXP_E 2
`define FTCT_EXP_A 1
`define FTCT_EXP_C 0
`define FTCT_EXP_RST 4'h_b
// status lag after frame-done-hold or token-pass, in cycles
`define FTCT_STAT_LAG 1
// confirmation codes
`define FTCT_CONF_POS 1'b1
`define FTCT_CONF_NEG 1'b0
`endif

/* File: core/ftct_tracker.v */
// Behaviour
// - positive only after all request frames return
// - unexpected frame before completion gives negative
// - one request per token, fixed order
// - own frame identified by FC, SA, FCS
// - first frames after capture are ours, in order
// - sync at token or foreign after own
// - expected status supplied or kept
// - status mismatch on FCS, E, A, C negative
// - A unset gives negative, optional terminate
// - C unset gives negative, optional terminate
// - E set or bad FCS negative
// - lost frame seen as count mismatch
// - corrupted own frame, false sync mismatch
// - never false positive from foreign frame
// - limit transparent FCS use
`timescale 1ns/1ps
`include "ftct_defs.vh"
module ftct_tracker #(
  parameter CNT_W = 8
) (
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  // request side
  input wire req_start_i,
  input wire req_exp_load_i,
  input wire [`FTCT_EXP_W-1:0] req_exp_i,
  input wire req_last_frame_i,
  input wire term_on_err_i,
  // transmitter status from the controller
  input wire tx_frame_done_hold_i,
  input wire tx_token_passed_i,
  input wire tx_end_delim_sent_i,
  input wire tx_frame_aborted_i,
  // receive side, one pulse per received frame end or token
  input wire rx_token_i,
  input wire rx_frame_end_i,
  input wire rx_own_match_i,
  input wire rx_fcs_valid_i,
  input wire rx_e_i,
  input wire rx_a_i,
  input wire rx_c_i,
  // outputs
  output wire busy_o,
  output reg conf_valid_o,
  output reg conf_pos_o,
  output reg [`FTCT_EXP_W-1:0] conf_fail_o,
  output reg req_terminate_o,
  output reg [CNT_W-1:0] tx_count_o,
  output reg [CNT_W-1:0] rx_count_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`FTCT_EXP_W-1:0] exp_reg;
  reg bad_reg;
  reg [`FTCT_EXP_W-1:0] fail_reg;
  reg seen_own_reg;
  reg stat_pend_reg;
  reg last_reg;
  wire [`FTCT_EXP_W-1:0] rx_vec;
  wire [`FTCT_EXP_W-1:0] mism;
  wire own_rx;
  wire foreign_rx;
  wire sync_pt;
  wire counts_eq;
  wire tx_ind;
  wire done_rx;
  wire frame_bad;

  assign busy_o = (state_reg != ST_IDLE);
  // controller status lags its indication by one cycle
  assign tx_ind = tx_frame_done_hold_i | tx_token_passed_i;
  assign rx_vec = {rx_fcs_valid_i, rx_e_i, rx_a_i, rx_c_i};
  assign mism = rx_vec ^ exp_reg;
  // the own-match input compares FC, SA and FCS; a frame that fails it counts as foreign
  assign own_rx = rx_frame_end_i & rx_own_match_i & busy_o;
  assign foreign_rx = rx_frame_end_i & ~rx_own_match_i;
  assign sync_pt = busy_o & (rx_token_i | (foreign_rx & seen_own_reg));
  assign counts_eq = (tx_count_o == rx_count_o);
  // a returning own frame beyond what was sent is unexpected
  assign frame_bad = own_rx & ((|mism) | (rx_count_o >= tx_count_o));
  assign done_rx = own_rx & last_reg & (state_reg == ST_WAIT)
                   & (rx_count_o + 1'b1 == tx_count_o);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (req_start_i) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if (stat_pend_reg & last_reg) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        state_next = ST_WAIT;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // any completion, good or bad, returns to idle exactly once
    if (busy_o & (frame_bad | (sync_pt & ~counts_eq) | done_rx | bad_reg)) begin
      state_next = ST_IDLE;
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      exp_reg <= `FTCT_EXP_RST;
      bad_reg <= 1'b0;
      fail_reg <= {`FTCT_EXP_W{1'b0}};
      seen_own_reg <= 1'b0;
      stat_pend_reg <= 1'b0;
      last_reg <= 1'b0;
      conf_valid_o <= 1'b0;
      conf_pos_o <= 1'b0;
      conf_fail_o <= {`FTCT_EXP_W{1'b0}};
      req_terminate_o <= 1'b0;
      tx_count_o <= {CNT_W{1'b0}};
      rx_count_o <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      state_reg <= state_next;
      conf_valid_o <= 1'b0;
      req_terminate_o <= 1'b0;
      stat_pend_reg <= tx_ind & (state_reg == ST_SEND);
      if (req_exp_load_i) begin
        exp_reg <= req_exp_i;
      end
      if (state_reg == ST_IDLE) begin
        if (req_start_i) begin
          tx_count_o <= {CNT_W{1'b0}};
          rx_count_o <= {CNT_W{1'b0}};
          bad_reg <= 1'b0;
          fail_reg <= {`FTCT_EXP_W{1'b0}};
          seen_own_reg <= 1'b0;
          last_reg <= 1'b0;
        end
      end else begin
        // ended and not aborted means a frame went out
        if (stat_pend_reg) begin
          if (tx_end_delim_sent_i & ~tx_frame_aborted_i) begin
            tx_count_o <= tx_count_o + 1'b1;
          end else begin
            bad_reg <= 1'b1;
          end
        end
        if (req_last_frame_i & tx_ind) begin
          last_reg <= 1'b1;
        end
        if (own_rx) begin
          rx_count_o <= rx_count_o + 1'b1;
          seen_own_reg <= 1'b1;
          fail_reg <= fail_reg | mism;
        end else if (foreign_rx) begin
          seen_own_reg <= 1'b0;
        end
        if (state_next == ST_IDLE) begin
          conf_valid_o <= 1'b1;
          conf_fail_o <= fail_reg | (own_rx ? mism : {`FTCT_EXP_W{1'b0}});
          if (done_rx & ~frame_bad & ~bad_reg & ~(|fail_reg)) begin
            conf_pos_o <= `FTCT_CONF_POS;
          end else begin
            conf_pos_o <= `FTCT_CONF_NEG;
            req_terminate_o <= term_on_err_i & (state_reg == ST_SEND);
          end
        end
      end
    end
  end
endmodule

/* File: tb/ftct_mac_model.sv */
`timescale 1ns/1ps
module ftct_mac_model(input clk_i,send_i,last_i,bad_i,
  output reg hold_o=0,pass_o=0,ed_o=0,abort_o=0);
  always @(posedge clk_i) begin
    hold_o<=send_i&!last_i;
    pass_o<=send_i&last_i;
    if(hold_o|pass_o) {ed_o,abort_o}<={!bad_i,bad_i};
    else if(send_i) {ed_o,abort_o}<=0;
  end
endmodule

/* File: tb/ftct_checker.sv */
`timescale 1ns/1ps
module ftct_checker #(parameter CNT_W=8)(input clk_i,resetn_i,req_start_i,rx_frame_end_i,
  busy_o,conf_valid_o,conf_pos_o,req_terminate_o,input [3:0] conf_fail_o,
  input [CNT_W-1:0] tx_count_o,rx_count_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_pos; conf_valid_o&&conf_pos_o; endsequence
  a_start_clear: assert property (req_start_i&&!busy_o |=> busy_o&&tx_count_o+rx_count_o==0)
    else $error("start");
  a_conf_pulse: assert property (conf_valid_o |=> !conf_valid_o) else $error("pulse");
  a_conf_idle: assert property (conf_valid_o |-> !busy_o) else $error("busy");
  a_pos_counts: assert property (s_pos |-> tx_count_o==rx_count_o) else $error("count");
  a_pos_clean: assert property (s_pos |-> conf_fail_o==0) else $error("fail");
  a_pos_cause: assert property (s_pos |-> $past(rx_frame_end_i)) else $error("cause");
  a_term_neg: assert property (req_terminate_o |-> conf_valid_o&&!conf_pos_o)
    else $error("term");
  a_idle_frozen: assert property (!busy_o&&!req_start_i |=> $stable(rx_count_o))
    else $error("idle");
endmodule
bind ftct_tracker ftct_checker #(.CNT_W(CNT_W)) i_ftct_checker(.*);

/* File: tb/tb_ftct_tracker.sv */
`timescale 1ns/1ps
module tb_ftct_tracker;
  reg clk_i=0,resetn_i=0,ce_i=1,req_start_i=0,req_exp_load_i=0,req_last_frame_i=0,snd=0,
    bad=0,term_on_err_i=0,rx_token_i=0,rx_frame_end_i=0,rx_own_match_i=0,got,gp,pe;
  reg [3:0] req_exp_i=0,cur=4'h_b,st=0;
  wire conf_valid_o,conf_pos_o,tx_frame_done_hold_i,tx_token_passed_i,tx_end_delim_sent_i,
    tx_frame_aborted_i,rx_fcs_valid_i,rx_e_i,rx_a_i,rx_c_i;
  integer miscompares=0,comparisons=0,seed=79,cyc=0,i,n,lo;
  assign {rx_fcs_valid_i,rx_e_i,rx_a_i,rx_c_i}=st;
  always #25 clk_i=~clk_i;
  ftct_mac_model i_ftct_mac_model(.clk_i,.send_i(snd),.last_i(req_last_frame_i),.bad_i(bad),
    .hold_o(tx_frame_done_hold_i),.pass_o(tx_token_passed_i),.ed_o(tx_end_delim_sent_i),
    .abort_o(tx_frame_aborted_i));
  ftct_tracker i_ftct_tracker(.*,.busy_o(),.conf_fail_o(),.req_terminate_o(),.tx_count_o(),
    .rx_count_o());
  always @(posedge clk_i) begin
    cyc=cyc+1;
    if(conf_valid_o) {got,gp}={1'b1,conf_pos_o};
    if(cyc>3000) begin
      miscompares=miscompares+1;
      give_verdict;
    end
  end
  task give_verdict; begin
    if(miscompares==0&&comparisons>0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end endtask
  task rx(input o,t); begin
    @(negedge clk_i) {rx_frame_end_i,rx_token_i,rx_own_match_i}={!t,t,o};
    @(negedge clk_i) {rx_frame_end_i,rx_token_i}=0;
  end endtask
  // lo above 0 loses the last frame, then a token or a foreign frame closes the round
  task rq(input integer nn); begin
    n=nn?nn:1+{$random(seed)}%4;
    lo={$random(seed)}%(n>1?3:2);
    {got,pe}={1'b0,lo==0};
    @(negedge clk_i) {req_exp_load_i,req_exp_i,term_on_err_i,req_start_i}={$random(seed)}|1;
    if(req_exp_load_i) cur=req_exp_i;
    for(i=1;i<=n;i=i+1) begin
      @(negedge clk_i) {req_start_i,req_exp_load_i,snd,req_last_frame_i}={3'b001,i==n};
      bad=i==n&&{$random(seed)}%8==0;
      pe=pe&!bad;
      @(negedge clk_i) snd=0;
      repeat(2) @(negedge clk_i);
    end
    for(i=1;i<n+(lo==0);i=i+1) begin
      st=cur;
      if({$random(seed)}%4==0) st=st^4'h_1<<{$random(seed)}%4;
      pe=pe&&st==cur;
      rx(1,0);
    end
    st=cur;
    if(lo) rx(0,lo==1);
    repeat(3) @(negedge clk_i);
    comparisons=comparisons+1;
    if(got!==1||gp!==pe) begin
      miscompares=miscompares+1;
      $display("mismatch %0t conf %b exp %b",$time,gp,pe);
    end
  end endtask
  initial begin
    repeat(3) @(negedge clk_i);
    resetn_i=1;
    repeat(40) rq(0);
    rq(4);
    give_verdict;
  end
endmodule
